/* rtl/ppfm_pkg.sv */
// Constants, register map and carrier types of the port pin function mux.
// Assumes a single 40 MHz system clock and a plain register port.
// Summary of operation
// - Port 0 direction is set per pin, three pins, one bit each.
// - Port 0 pull-up is connected only when its option bit is set.
// - Port 1 direction is set per pin, eight pins, one bit each.
// - Port 1 pull-up follows its option bit on each input pin.
// - Port 2 direction is set per bit; port 2 has no pull-up option.
// - Port 3 direction is set per bit.
// - Port 3 pull-up follows its option bit on each input pin.
// - Port or alternate mode is chosen per pin on ports 0, 1, 3 and 4; port 2 has no alternate mode.
// - After reset, port 1 bits 0 to 2 are digital inputs.
// - After reset, all port 2 pins are analog inputs.
// - Each external interrupt pin detects rising, falling or both edges.
// - Alternate switch routes timer I/O to port 3 bit 4 in small variants.
// - Alternate switch routes serial 11 clock and data input to port 4 bits 0, 1.
// - First timer input feeds timer 00 count clock and both capture triggers.
// - Second timer input feeds only capture register A trigger.
package ppfm_pkg;
   // Register offsets
   localparam logic [4:0] ADDR_P0_OUT   = 5'h00;
   localparam logic [4:0] ADDR_P1_OUT   = 5'h01;
   localparam logic [4:0] ADDR_P2_OUT   = 5'h02;
   localparam logic [4:0] ADDR_P3_OUT   = 5'h03;
   localparam logic [4:0] ADDR_P4_OUT   = 5'h04;
   localparam logic [4:0] ADDR_P0_DIR   = 5'h05;
   localparam logic [4:0] ADDR_P1_DIR   = 5'h06;
   localparam logic [4:0] ADDR_P2_DIR   = 5'h07;
   localparam logic [4:0] ADDR_P3_DIR   = 5'h08;
   localparam logic [4:0] ADDR_P4_DIR   = 5'h09;
   localparam logic [4:0] ADDR_P0_PU    = 5'h0a;
   localparam logic [4:0] ADDR_P1_PU    = 5'h0b;
   localparam logic [4:0] ADDR_P3_PU    = 5'h0c;
   localparam logic [4:0] ADDR_P4_PU    = 5'h0d;
   localparam logic [4:0] ADDR_P0_ALT   = 5'h0e;
   localparam logic [4:0] ADDR_P1_ALT   = 5'h0f;
   localparam logic [4:0] ADDR_P2_ANA   = 5'h10;
   localparam logic [4:0] ADDR_P3_ALT   = 5'h11;
   localparam logic [4:0] ADDR_P4_ALT   = 5'h12;
   localparam logic [4:0] ADDR_MUXSW    = 5'h13;
   localparam logic [4:0] ADDR_EGP      = 5'h14;
   localparam logic [4:0] ADDR_EGN      = 5'h15;
   localparam logic [4:0] ADDR_P0_IN    = 5'h16;
   localparam logic [4:0] ADDR_P1_IN    = 5'h17;
   localparam logic [4:0] ADDR_P2_IN    = 5'h18;
   localparam logic [4:0] ADDR_P3_IN    = 5'h19;
   localparam logic [4:0] ADDR_P4_IN    = 5'h1a;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h1b;
   // Reset values; direction 1 = input
   localparam logic [7:0] DIR_RST  = 8'hff;
   localparam logic [7:0] P1_ALT_RST = 8'h00;
   localparam logic [7:0] P2_ANA_RST = 8'hff;
   // Alternate switch register fields
   localparam int SW_TIMER_P34 = 0;
   localparam int SW_SERIAL_CHANNEL_11_P4  = 1;
   // Pin counts and external interrupt count
   localparam int P0_W  = 3;
   localparam int P4_W  = 3;
   localparam int IRQ_N = 8;
   // Pin carrier: output level, output enable (low = drive), pull-up enable
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pu;
   } ppfm_pin_t;
   // Peripheral side signals going to the pins
   typedef struct packed {
      logic timer00_out;
      logic timer_h1_out;
      logic sck11_out;
      logic sck11_oe;
      logic so10_out;
      logic sck10_out;
      logic sck10_oe;
      logic txd6_out;
      logic timer_h0_out;
      logic timer50_out;
      logic timer51_out;
   } ppfm_periph_t;
   // Decoded peripheral inputs
   typedef struct packed {
      logic timer00_count;
      logic timer00_capture_a;
      logic timer00_capture_b;
      logic timer51_count_in;
      logic serial11_clk_in;
      logic serial11_data_in;
      logic serial11_chip_select_in;
   } ppfm_periph_in_t;
endpackage

/* rtl/ppfm_edge.sv */
// Edge detector for the external interrupt inputs.
// Assumes inputs already synchronous to the clock.
`timescale 1ns/10ps
module ppfm_edge #(
   parameter int N = 8
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [N-1:0] level_in,
   input  wire logic [N-1:0] rise_en,
   input  wire logic [N-1:0] fall_en,
   output logic      [N-1:0] req
);
   typedef struct packed {
      logic [N-1:0] prev;
      logic [N-1:0] req;
   } ppfm_edge_state_t;
   ppfm_edge_state_t state_reg;
   ppfm_edge_state_t state_next;

   // Rising, falling or both, per input
   always_comb
   begin
      state_next = state_reg;
      state_next.prev = level_in;
      state_next.req = (level_in & ~state_reg.prev & rise_en)
                     | (~level_in & state_reg.prev & fall_en);
   end

   // Prev resets low: a pin already high at release is not an edge only if rise is off
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign req = state_reg.req;
endmodule // ppfm_edge

/* rtl/ppfm_top.sv */
// Port 0 to 4 pin function mux with per-pin direction; pull-up and alternate select on all ports except port 2.
// Assumes pin inputs synchronous to clock; the pad ring resolves out/oe_n/pu.
`timescale 1ns/10ps
module ppfm_top (
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire logic [4:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [7:0]                reg_rdata,
   input  wire logic [7:0]                p0_in,
   input  wire logic [7:0]                p1_in,
   input  wire logic [7:0]                p2_in,
   input  wire logic [7:0]                p3_in,
   input  wire logic [7:0]                p4_in,
   output ppfm_pkg::ppfm_pin_t            p0_pin,
   output ppfm_pkg::ppfm_pin_t            p1_pin,
   output ppfm_pkg::ppfm_pin_t            p2_pin,
   output ppfm_pkg::ppfm_pin_t            p3_pin,
   output ppfm_pkg::ppfm_pin_t            p4_pin,
   output logic      [7:0]                p2_analog_en,
   input  wire ppfm_pkg::ppfm_periph_t    periph,
   output ppfm_pkg::ppfm_periph_in_t      periph_in,
   output logic      [ppfm_pkg::IRQ_N-1:0] ext_irq_req
);
   typedef struct packed {
      logic [7:0] p0_out;
      logic [7:0] p1_out;
      logic [7:0] p2_out;
      logic [7:0] p3_out;
      logic [7:0] p4_out;
      logic [7:0] port0_direction_reg;
      logic [7:0] port1_direction_reg;
      logic [7:0] port2_direction_reg;
      logic [7:0] port3_direction_reg;
      logic [7:0] port4_direction_reg;
      logic [7:0] port0_pullup_reg;
      logic [7:0] port1_pullup_reg;
      logic [7:0] port3_pullup_reg;
      logic [7:0] port4_pullup_reg;
      logic [7:0] p0_alt;
      logic [7:0] p1_alt;
      logic [7:0] p2_ana;
      logic [7:0] p3_alt;
      logic [7:0] p4_alt;
      logic [7:0] alt_switch_ctrl_reg;
      logic [7:0] edge_rise;
      logic [7:0] edge_fall;
      logic [7:0] irq_seen;
      logic [7:0] rdata;
      ppfm_pkg::ppfm_pin_t p0_pin;
      ppfm_pkg::ppfm_pin_t p1_pin;
      ppfm_pkg::ppfm_pin_t p2_pin;
      ppfm_pkg::ppfm_pin_t p3_pin;
      ppfm_pkg::ppfm_pin_t p4_pin;
      ppfm_pkg::ppfm_periph_in_t pin_in;
   } ppfm_state_t;

   ppfm_state_t state_reg;
   ppfm_state_t state_next;
   logic [ppfm_pkg::IRQ_N-1:0] irq_level;
   logic [ppfm_pkg::IRQ_N-1:0] irq_req;

   // Pin drive: alternate output wins over latch when selected
   function automatic ppfm_pkg::ppfm_pin_t pin_drive(
      input logic [7:0] latch,
      input logic [7:0] dir,
      input logic [7:0] alt,
      input logic [7:0] alt_out,
      input logic [7:0] alt_oe,
      input logic [7:0] pu
   );
      ppfm_pkg::ppfm_pin_t p;
      p.out  = (alt & alt_out) | (~alt & latch);
      p.oe_n = (alt & ~alt_oe) | (~alt & dir);
      p.pu   = pu & p.oe_n; // Pull-up only while input
      return p;
   endfunction

   // External interrupt levels from their pins
   always_comb
   begin
      irq_level = '0;
      irq_level[0] = p0_in[0];
      irq_level[1] = p3_in[0];
      irq_level[2] = p3_in[1];
      irq_level[3] = p3_in[2];
      irq_level[4] = p3_in[3];
      irq_level[5] = p1_in[6];
      irq_level[6] = p4_in[2];
      irq_level[7] = p0_in[2];
   end

   ppfm_edge #(
      .N        (ppfm_pkg::IRQ_N)
   ) u_edge (
      .clock    (clock),
      .rst      (rst),
      .level_in (irq_level),
      .rise_en  (state_reg.edge_rise),
      .fall_en  (state_reg.edge_fall),
      .req      (irq_req)
   );

   // Register writes, reads, pin drive and input routing
   always_comb
   begin
      logic [7:0] a_out;
      logic [7:0] a_oe;
      logic       sw_t;
      logic       sw_s;
      a_out = '0;
      a_oe  = '0;
      sw_t  = state_reg.alt_switch_ctrl_reg[ppfm_pkg::SW_TIMER_P34];
      sw_s  = state_reg.alt_switch_ctrl_reg[ppfm_pkg::SW_SERIAL_CHANNEL_11_P4];
      state_next = state_reg;
      if (reg_wr)
      begin
         unique case (reg_addr)
            ppfm_pkg::ADDR_P0_OUT:   state_next.p0_out = reg_wdata;
            ppfm_pkg::ADDR_P1_OUT:   state_next.p1_out = reg_wdata;
            ppfm_pkg::ADDR_P2_OUT:   state_next.p2_out = reg_wdata;
            ppfm_pkg::ADDR_P3_OUT:   state_next.p3_out = reg_wdata;
            ppfm_pkg::ADDR_P4_OUT:   state_next.p4_out = reg_wdata;
            ppfm_pkg::ADDR_P0_DIR:   state_next.port0_direction_reg = reg_wdata;
            ppfm_pkg::ADDR_P1_DIR:   state_next.port1_direction_reg = reg_wdata;
            ppfm_pkg::ADDR_P2_DIR:   state_next.port2_direction_reg = reg_wdata;
            ppfm_pkg::ADDR_P3_DIR:   state_next.port3_direction_reg = reg_wdata;
            ppfm_pkg::ADDR_P4_DIR:   state_next.port4_direction_reg = reg_wdata;
            ppfm_pkg::ADDR_P0_PU:    state_next.port0_pullup_reg = reg_wdata;
            ppfm_pkg::ADDR_P1_PU:    state_next.port1_pullup_reg = reg_wdata;
            ppfm_pkg::ADDR_P3_PU:    state_next.port3_pullup_reg = reg_wdata;
            ppfm_pkg::ADDR_P4_PU:    state_next.port4_pullup_reg = reg_wdata;
            ppfm_pkg::ADDR_P0_ALT:   state_next.p0_alt = reg_wdata;
            ppfm_pkg::ADDR_P1_ALT:   state_next.p1_alt = reg_wdata;
            ppfm_pkg::ADDR_P2_ANA:   state_next.p2_ana = reg_wdata;
            ppfm_pkg::ADDR_P3_ALT:   state_next.p3_alt = reg_wdata;
            ppfm_pkg::ADDR_P4_ALT:   state_next.p4_alt = reg_wdata;
            ppfm_pkg::ADDR_MUXSW:    state_next.alt_switch_ctrl_reg = reg_wdata;
            ppfm_pkg::ADDR_EGP:      state_next.edge_rise = reg_wdata;
            ppfm_pkg::ADDR_EGN:      state_next.edge_fall = reg_wdata;
            default:                 ;
         endcase
      end
      // Sticky edge seen flags: write one clears, a new edge wins
      if (reg_wr && reg_addr == ppfm_pkg::ADDR_IRQ_STAT)
         state_next.irq_seen = state_reg.irq_seen & ~reg_wdata;
      state_next.irq_seen = state_next.irq_seen | irq_req;

      // Read data stands the cycle after the strobe only
      state_next.rdata = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            ppfm_pkg::ADDR_P0_OUT:   state_next.rdata = state_reg.p0_out;
            ppfm_pkg::ADDR_P1_OUT:   state_next.rdata = state_reg.p1_out;
            ppfm_pkg::ADDR_P2_OUT:   state_next.rdata = state_reg.p2_out;
            ppfm_pkg::ADDR_P3_OUT:   state_next.rdata = state_reg.p3_out;
            ppfm_pkg::ADDR_P4_OUT:   state_next.rdata = state_reg.p4_out;
            ppfm_pkg::ADDR_P0_DIR:   state_next.rdata = state_reg.port0_direction_reg;
            ppfm_pkg::ADDR_P1_DIR:   state_next.rdata = state_reg.port1_direction_reg;
            ppfm_pkg::ADDR_P2_DIR:   state_next.rdata = state_reg.port2_direction_reg;
            ppfm_pkg::ADDR_P3_DIR:   state_next.rdata = state_reg.port3_direction_reg;
            ppfm_pkg::ADDR_P4_DIR:   state_next.rdata = state_reg.port4_direction_reg;
            ppfm_pkg::ADDR_P0_PU:    state_next.rdata = state_reg.port0_pullup_reg;
            ppfm_pkg::ADDR_P1_PU:    state_next.rdata = state_reg.port1_pullup_reg;
            ppfm_pkg::ADDR_P3_PU:    state_next.rdata = state_reg.port3_pullup_reg;
            ppfm_pkg::ADDR_P4_PU:    state_next.rdata = state_reg.port4_pullup_reg;
            ppfm_pkg::ADDR_P0_ALT:   state_next.rdata = state_reg.p0_alt;
            ppfm_pkg::ADDR_P1_ALT:   state_next.rdata = state_reg.p1_alt;
            ppfm_pkg::ADDR_P2_ANA:   state_next.rdata = state_reg.p2_ana;
            ppfm_pkg::ADDR_P3_ALT:   state_next.rdata = state_reg.p3_alt;
            ppfm_pkg::ADDR_P4_ALT:   state_next.rdata = state_reg.p4_alt;
            ppfm_pkg::ADDR_MUXSW:    state_next.rdata = state_reg.alt_switch_ctrl_reg;
            ppfm_pkg::ADDR_EGP:      state_next.rdata = state_reg.edge_rise;
            ppfm_pkg::ADDR_EGN:      state_next.rdata = state_reg.edge_fall;
            ppfm_pkg::ADDR_P0_IN:    state_next.rdata = p0_in;
            ppfm_pkg::ADDR_P1_IN:    state_next.rdata = p1_in;
            ppfm_pkg::ADDR_P2_IN:    state_next.rdata = p2_in & ~state_reg.p2_ana; // Analog pins read 0
            ppfm_pkg::ADDR_P3_IN:    state_next.rdata = p3_in;
            ppfm_pkg::ADDR_P4_IN:    state_next.rdata = p4_in;
            ppfm_pkg::ADDR_IRQ_STAT: state_next.rdata = state_reg.irq_seen;
            default:                 state_next.rdata = '0;
         endcase
      end

      // Port 0: bit 1 timer 00 output
      a_out = '0;
      a_oe  = '0;
      a_out[1] = periph.timer00_out;
      a_oe[1]  = 1'b1;
      state_next.p0_pin = pin_drive(state_reg.p0_out, state_reg.port0_direction_reg, state_reg.p0_alt,
                                    a_out, a_oe, state_reg.port0_pullup_reg);
      // Port 1: serial 10, UART 6 and timer outputs
      a_out = '0;
      a_oe  = '0;
      a_out[0] = periph.sck10_out;
      a_oe[0]  = periph.sck10_oe;
      a_out[2] = periph.so10_out;
      a_oe[2]  = 1'b1;
      a_out[3] = periph.txd6_out;
      a_oe[3]  = 1'b1;
      a_out[5] = periph.timer_h0_out;
      a_oe[5]  = 1'b1;
      a_out[6] = periph.timer_h1_out;
      a_oe[6]  = 1'b1;
      a_out[7] = periph.timer50_out;
      a_oe[7]  = 1'b1;
      state_next.p1_pin = pin_drive(state_reg.p1_out, state_reg.port1_direction_reg, state_reg.p1_alt,
                                    a_out, a_oe, state_reg.port1_pullup_reg);
      // Port 2: analog pins float, no pull-up option exists
      // Next analog select used so the pin and the analog flag switch on the same edge
      state_next.p2_pin = pin_drive(state_reg.p2_out, state_reg.port2_direction_reg | state_next.p2_ana,
                                    8'h00, 8'h00, 8'h00, 8'h00);
      // Port 3: timer 51 on bit 3, timer H1 copied to bit 4 by the switch, still on port 1 bit 6
      a_out = '0;
      a_oe  = '0;
      a_out[3] = periph.timer51_out;
      a_oe[3]  = 1'b1;
      a_out[4] = sw_t & periph.timer_h1_out;
      a_oe[4]  = sw_t;
      state_next.p3_pin = pin_drive(state_reg.p3_out, state_reg.port3_direction_reg, state_reg.p3_alt,
                                    a_out, a_oe, state_reg.port3_pullup_reg);
      // Port 4: serial 11 clock moved to bit 0 by the switch
      a_out = '0;
      a_oe  = '0;
      a_out[0] = sw_s & periph.sck11_out;
      a_oe[0]  = sw_s & periph.sck11_oe;
      state_next.p4_pin = pin_drive(state_reg.p4_out, state_reg.port4_direction_reg, state_reg.p4_alt,
                                    a_out, a_oe, state_reg.port4_pullup_reg);

      // Peripheral inputs, gated by each pin's alternate select
      state_next.pin_in.timer00_count     = state_reg.p0_alt[0] & p0_in[0];
      state_next.pin_in.timer00_capture_b = state_reg.p0_alt[0] & p0_in[0];
      state_next.pin_in.timer00_capture_a = (state_reg.p0_alt[0] & p0_in[0])
                                          | (state_reg.p0_alt[1] & p0_in[1]);
      state_next.pin_in.timer51_count_in  = sw_t ? (state_reg.p3_alt[4] & p3_in[4])
                                                 : (state_reg.p3_alt[3] & p3_in[3]);
      state_next.pin_in.serial11_clk_in   = sw_s ? (state_reg.p4_alt[0] & p4_in[0])
                                                 : (state_reg.p3_alt[5] & p3_in[5]);
      state_next.pin_in.serial11_data_in  = sw_s ? (state_reg.p4_alt[1] & p4_in[1])
                                                 : (state_reg.p3_alt[6] & p3_in[6]);
      state_next.pin_in.serial11_chip_select_in = state_reg.p4_alt[2] & p4_in[2];
   end

   // Reset: all inputs, port 1 digital, port 2 analog
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= '0;
         state_reg.port0_direction_reg <= ppfm_pkg::DIR_RST;
         state_reg.port1_direction_reg <= ppfm_pkg::DIR_RST;
         state_reg.port2_direction_reg <= ppfm_pkg::DIR_RST;
         state_reg.port3_direction_reg <= ppfm_pkg::DIR_RST;
         state_reg.port4_direction_reg <= ppfm_pkg::DIR_RST;
         state_reg.p1_alt <= ppfm_pkg::P1_ALT_RST;
         state_reg.p2_ana <= ppfm_pkg::P2_ANA_RST;
         state_reg.p0_pin.oe_n <= 8'hff;
         state_reg.p1_pin.oe_n <= 8'hff;
         state_reg.p2_pin.oe_n <= 8'hff;
         state_reg.p3_pin.oe_n <= 8'hff;
         state_reg.p4_pin.oe_n <= 8'hff;
      end
      else
         state_reg <= state_next;
   end

   // Output registers straight out
   assign reg_rdata    = state_reg.rdata;
   assign p0_pin       = state_reg.p0_pin;
   assign p1_pin       = state_reg.p1_pin;
   assign p2_pin       = state_reg.p2_pin;
   assign p3_pin       = state_reg.p3_pin;
   assign p4_pin       = state_reg.p4_pin;
   assign p2_analog_en = state_reg.p2_ana;
   assign periph_in    = state_reg.pin_in;
   assign ext_irq_req  = irq_req;
endmodule // ppfm_top

/* bench/ppfm_top_sva.sv */
// Checker for the port pin function mux, watching only the top ports.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/10ps
module ppfm_top_sva (
   input wire logic                      clock,
   input wire logic                      rst,
   input wire logic [4:0]                reg_addr,
   input wire logic [7:0]                reg_wdata,
   input wire logic                      reg_wr,
   input wire logic [7:0]                p0_in,
   input wire ppfm_pkg::ppfm_pin_t       p0_pin,
   input wire ppfm_pkg::ppfm_pin_t       p1_pin,
   input wire ppfm_pkg::ppfm_pin_t       p2_pin,
   input wire ppfm_pkg::ppfm_pin_t       p3_pin,
   input wire logic [7:0]                p2_analog_en,
   input wire ppfm_pkg::ppfm_periph_in_t periph_in,
   input wire logic [7:0]                ext_irq_req
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Pull-ups only ever sit on pins that are not driven
   a_p0_pull_input: assert property ((p0_pin.pu[2:0] & ~p0_pin.oe_n[2:0]) == 3'h0)
      else $error("port 0 pull-up on a driven pin");
   a_p1_pull_input: assert property ((p1_pin.pu & ~p1_pin.oe_n) == 8'h00)
      else $error("port 1 pull-up on a driven pin");
   a_p3_pull_input: assert property ((p3_pin.pu & ~p3_pin.oe_n) == 8'h00)
      else $error("port 3 pull-up on a driven pin");
   a_p2_no_pull: assert property (p2_pin.pu == 8'h00)
      else $error("port 2 shows a pull-up");
   // Analog mode must keep the output stage off
   a_p2_analog_in: assert property ((p2_analog_en & ~p2_pin.oe_n) == 8'h00)
      else $error("analog port 2 pin driven");
   // Direction writes reach the pins two edges later
   a_p1_dir_apply: assert property ((reg_wr && reg_addr == ppfm_pkg::ADDR_P1_DIR) |->
      ##2 p1_pin.oe_n == $past(reg_wdata, 2)) else $error("port 1 direction not applied");
   a_p3_dir_apply: assert property ((reg_wr && reg_addr == ppfm_pkg::ADDR_P3_DIR) |->
      ##2 ((p3_pin.oe_n ^ $past(reg_wdata, 2)) & 8'h0f) == 8'h00) else $error("port 3 direction not applied");
   // A request needs a real level change shortly before it
   a_irq_has_cause: assert property (ext_irq_req[0] |->
      ($past(p0_in[0]) != $past(p0_in[0], 2)) || ($past(p0_in[0], 2) != $past(p0_in[0], 3)))
      else $error("interrupt request without pin edge");
   // One pin feeds both the count clock and the second capture
   a_ti_count_cap: assert property (periph_in.timer00_count == periph_in.timer00_capture_b)
      else $error("count clock and capture b differ");
endmodule // ppfm_top_sva

bind ppfm_top ppfm_top_sva u_sva (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .p0_in(p0_in), .p0_pin(p0_pin), .p1_pin(p1_pin), .p2_pin(p2_pin), .p3_pin(p3_pin),
   .p2_analog_en(p2_analog_en), .periph_in(periph_in), .ext_irq_req(ext_irq_req));

/* bench/ppfm_top_tb.sv */
// Self-checking bench for the port pin function mux.
// Assumes the package register map; drives all ports itself.
`timescale 1ns/10ps
module ppfm_top_tb;
   logic                      clock = 1'b0;
   logic                      rst = 1'b1;
   logic [4:0]                reg_addr = 5'h00;
   logic [7:0]                reg_wdata = 8'h00;
   logic                      reg_wr = 1'b0;
   logic                      reg_rd = 1'b0;
   logic [7:0]                reg_rdata;
   logic [7:0]                p0_in = 8'h00;
   logic [7:0]                p3_in = 8'h00;
   logic [7:0]                p4_in = 8'h00;
   ppfm_pkg::ppfm_pin_t       p0_pin;
   ppfm_pkg::ppfm_pin_t       p1_pin;
   ppfm_pkg::ppfm_pin_t       p2_pin;
   ppfm_pkg::ppfm_pin_t       p3_pin;
   ppfm_pkg::ppfm_pin_t       p4_pin;
   ppfm_pkg::ppfm_periph_t    periph = '0;
   ppfm_pkg::ppfm_periph_in_t periph_in;
   logic [7:0]                p2_analog_en;
   logic [7:0]                ext_irq_req;
   int                        fails = 0;
   int                        n_tests = 0;
   int                        cycles = 0;

   always #12.5 clock = ~clock;

   ppfm_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p0_in(p0_in), .p1_in(8'h00), .p2_in(8'h00), .p3_in(p3_in),
      .p4_in(p4_in), .p0_pin(p0_pin), .p1_pin(p1_pin), .p2_pin(p2_pin), .p3_pin(p3_pin), .p4_pin(p4_pin),
      .p2_analog_en(p2_analog_en), .periph(periph), .periph_in(periph_in), .ext_irq_req(ext_irq_req));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Read data only stands in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp, what);
   endtask
   // Pins follow a register one edge after it changes; port 2 pins follow the analog select on the same edge
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic t_reset;
      check(p2_analog_en, 8'hff, "analog after reset");
      check({5'h00, p1_pin.oe_n[2:0]}, 8'h07, "port 1 low pins");
      rd(ppfm_pkg::ADDR_P1_ALT, 8'h00, "port 1 alt reset");
      rd(ppfm_pkg::ADDR_P2_ANA, 8'hff, "port 2 analog reset");
      rd(ppfm_pkg::ADDR_P1_DIR, 8'hff, "port 1 dir reset");
      rd(5'h1f, 8'h00, "unmapped read");
   endtask
   task automatic t_port0;
      wr(ppfm_pkg::ADDR_P0_OUT, 8'h05);
      wr(ppfm_pkg::ADDR_P0_DIR, 8'hfa);
      settle;
      check(p0_pin.oe_n & 8'h07, 8'h02, "port 0 drive");
      check(p0_pin.out & 8'h05, 8'h05, "port 0 level");
      wr(ppfm_pkg::ADDR_P0_DIR, 8'hff);
      wr(ppfm_pkg::ADDR_P0_PU, 8'h02);
      settle;
      check(p0_pin.pu & 8'h07, 8'h02, "port 0 pull-up on");
      wr(ppfm_pkg::ADDR_P0_PU, 8'h00);
      settle;
      check(p0_pin.pu & 8'h07, 8'h00, "port 0 pull-up off");
   endtask
   task automatic t_ports;
      wr(ppfm_pkg::ADDR_P1_DIR, 8'hf0);
      wr(ppfm_pkg::ADDR_P1_PU, 8'h3c);
      wr(ppfm_pkg::ADDR_P2_ANA, 8'h00);
      wr(ppfm_pkg::ADDR_P2_DIR, 8'h0f);
      wr(ppfm_pkg::ADDR_P3_DIR, 8'h0e);
      wr(ppfm_pkg::ADDR_P3_PU, 8'hff);
      settle;
      check(p1_pin.oe_n, 8'hf0, "port 1 drive");
      check(p1_pin.pu, 8'h30, "port 1 pull-up");
      check(p2_analog_en, 8'h00, "port 2 digital");
      check(p2_pin.oe_n, 8'h0f, "port 2 drive");
      check(p2_pin.pu, 8'h00, "port 2 pull-up");
      check(p3_pin.oe_n, 8'h0e, "port 3 drive");
      check(p3_pin.pu, 8'h0e, "port 3 pull-up");
   endtask
   task automatic t_alt;
      wr(ppfm_pkg::ADDR_P0_OUT, 8'h00);
      wr(ppfm_pkg::ADDR_P0_DIR, 8'h00);
      wr(ppfm_pkg::ADDR_P0_ALT, 8'h02);
      periph.timer00_out <= 1'b1;
      periph.timer_h1_out <= 1'b1;
      settle;
      check(p0_pin.out & 8'h03, 8'h02, "timer out on pin 1 only");
      wr(ppfm_pkg::ADDR_MUXSW, 8'h01);
      wr(ppfm_pkg::ADDR_P3_ALT, 8'h10);
      wr(ppfm_pkg::ADDR_P3_DIR, 8'hef);
      settle;
      check({7'h00, p3_pin.out[4]}, 8'h01, "switched timer high");
      periph.timer_h1_out <= 1'b0;
      settle;
      check({7'h00, p3_pin.out[4]}, 8'h00, "switched timer low");
      wr(ppfm_pkg::ADDR_MUXSW, 8'h03);
      wr(ppfm_pkg::ADDR_P4_ALT, 8'h03);
      periph.sck11_out <= 1'b1;
      periph.sck11_oe  <= 1'b1;
      for (int k = 1; k < 3; k++)
      begin
         p4_in <= 8'(k);
         settle;
         check({6'h00, periph_in.serial11_data_in, periph_in.serial11_clk_in}, 8'(k), "serial 11 inputs");
      end
      check({6'h00, p4_pin.oe_n[0], p4_pin.out[0]}, 8'h01, "serial 11 clock on port 4");
      p3_in <= 8'h10;
      settle;
      check({7'h00, periph_in.timer51_count_in}, 8'h01, "switched timer input");
      wr(ppfm_pkg::ADDR_P0_DIR, 8'hff);
      wr(ppfm_pkg::ADDR_P0_ALT, 8'h03);
      p0_in <= 8'h01;
      settle;
      check({5'h00, periph_in.timer00_count, periph_in.timer00_capture_a, periph_in.timer00_capture_b},
         8'h07, "first timer input");
      p0_in <= 8'h02;
      settle;
      check({5'h00, periph_in.timer00_count, periph_in.timer00_capture_a, periph_in.timer00_capture_b},
         8'h02, "second timer input");
      rd(ppfm_pkg::ADDR_P0_IN, 8'h02, "port 0 input read");
   endtask
   // Rising, falling and both edges, one pass each
   task automatic t_irq;
      logic [7:0] n;
      p0_in <= 8'h00;
      for (int m = 1; m < 4; m++)
      begin
         wr(ppfm_pkg::ADDR_EGP, {7'h00, m[0]});
         wr(ppfm_pkg::ADDR_EGN, {7'h00, m[1]});
         for (int k = 0; k < 2; k++)
         begin
            p0_in <= {7'h00, k == 0};
            n = 8'h00;
            repeat (4)
            begin
               @(posedge clock);
               #1;
               n = n + ext_irq_req[0];
            end
            check(n, {7'h00, (k == 0) ? m[0] : m[1]}, "edge request count");
         end
      end
      // Seen flag stays set until software clears it
      rd(ppfm_pkg::ADDR_IRQ_STAT, 8'h01, "edge seen flag");
      wr(ppfm_pkg::ADDR_IRQ_STAT, 8'h01);
      rd(ppfm_pkg::ADDR_IRQ_STAT, 8'h00, "edge seen cleared");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, well above the roughly 125 cycles needed
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fails = fails + 1;
         give_verdict;
      end
   end
   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      t_reset;
      t_port0;
      t_ports;
      t_alt;
      t_irq;
      give_verdict;
   end
endmodule // ppfm_top_tb
